/* File: motor_lock_pkg.sv */
package motor_lock_pkg;

   // ***********************************
   // Clock and timing
   // ***********************************
   localparam int CLOCK_HZ          = 125_000_000;
   localparam int CLOCK_PERIOD_NS   = 8;
   localparam int DEAD_STEP_NS      = 40;
   localparam int DEAD_STEP_CYCLES  = (DEAD_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int PWM_SLOW_HZ       = 25_000;
   localparam int PWM_FAST_HZ       = 50_000;
   localparam int PWM_SLOW_CYCLES   = CLOCK_HZ / PWM_SLOW_HZ;
   localparam int PWM_FAST_CYCLES   = CLOCK_HZ / PWM_FAST_HZ;
   localparam int QUALIFY_TIME_US   = 1000;
   localparam int LOCK_OFF_TIME_US  = 100_000;
   localparam int BRAKE_STEP_US     = 100;
   localparam int CYCLES_PER_US     = CLOCK_HZ / 1_000_000;
   localparam int INTEG_DIV_CYCLES  = 64;

   // ***********************************
   // Thresholds and scaling
   // ***********************************
   localparam logic [15:0] NO_MOTOR_MA  = 16'd140;
   localparam int          SCALE_SHIFT  = 4;
   localparam int          KTC_SHIFT    = 16;
   localparam logic [2:0]  SECTOR_LAST  = 3'h5;
   localparam logic [2:0]  SECTOR_HALF  = 3'h3;
   localparam logic [2:0]  OL_STEPS     = 3'h6;

   // ***********************************
   // Fault flag positions
   // ***********************************
   localparam int FLAG_CURRENT   = 0;
   localparam int FLAG_SPEED     = 1;
   localparam int FLAG_VELCONST  = 2;
   localparam int FLAG_NO_MOTOR  = 3;
   localparam int FLAG_OL_STUCK  = 4;
   localparam int FLAG_CL_STUCK  = 5;

   // ***********************************
   // Reset values and encodings
   // ***********************************
   localparam logic [5:0] FLAGS_RESET    = 6'h00;
   localparam logic [1:0] TACH_OL_FOLLOW = 2'h0;
   localparam logic [1:0] TACH_OL_HIGH   = 2'h1;
   localparam logic [1:0] TACH_OL_FIRST  = 2'h2;

   typedef enum logic [1:0] {
      ST_DRIVE = 2'b00,
      ST_BRAKE = 2'b01,
      ST_HIZ   = 2'b10
   } drive_state_t;

endpackage

/* File: motor_lock_ctl.sv */
`timescale 1ns/1ns
// How it works
// RL1 - Speed BEMF far above amplitude sets lock
// RL2 - Seven-bit shift/value settings scale current, speed
// RL3 - Integrate BEMF each half cycle as constant
// RL4 - Constant outside band for time sets lock
// RL5 - Handoff with current not above 140mA: no-motor
// RL6 - Open loop: no BEMF one cycle sets lock
// RL7 - Commutation period over twice previous sets lock
// RL8 - Mechanical and inductive surge individually disabled
// RL9 - Mechanical surge clamps amplitude above speed BEMF
// RL10 - Mode bit: clamp always, or at 24V
// RL11 - Inductive: high sides off, low after delay
// RL12 - Zero brake delay means no braking
// RL13 - Five-bit dead time, 40 to 1280 ns
// RL14 - Software picks dead time avoiding shoot-through
// RL15 - Rate bit selects 25 or 50 kHz
// RL16 - Four-bit tach divider up to 32 poles
// RL17 - Codes 1..3 give 4, 6, 8 pole ratios
// RL18 - Non-even divide gives uneven tach duty
// RL19 - Tach high when locked, follows drive otherwise
// RL20 - Open-loop tach: follow, high, first start only
// RL21 - Flags set even disabled, clear on restart
// RL22 - Enabled fault: hi-z with surge, retry later
// RL23 - Six enable bits gate each fault
// RL24 - Tach divider counts half cycles, resets on restart
module motor_lock_ctl
   import motor_lock_pkg::*;
#(
   parameter int QUALIFY_CYCLES    = QUALIFY_TIME_US * CYCLES_PER_US,
   parameter int LOCK_OFF_CYCLES   = LOCK_OFF_TIME_US * CYCLES_PER_US,
   parameter int BRAKE_STEP_CYCLES = BRAKE_STEP_US * CYCLES_PER_US
) (
   // Clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RST_IN,
   // Configuration
   input  wire logic [6:0]  RESISTANCE_SETTING_IN,
   input  wire logic [6:0]  VELCONST_SETTING_IN,
   input  wire logic [5:0]  LOCK_SCHEME_ENABLES_IN,
   input  wire logic        MECH_SURGE_ENABLE_IN,
   input  wire logic        MECH_SURGE_MODE_IN,
   input  wire logic        INDUCTIVE_SURGE_ENABLE_IN,
   input  wire logic [2:0]  BRAKE_DELAY_FIELD_IN,
   input  wire logic [4:0]  DEAD_TIME_FIELD_IN,
   input  wire logic        PWM_RATE_SELECT_IN,
   input  wire logic [3:0]  TACH_DIVIDER_FIELD_IN,
   input  wire logic [1:0]  TACH_OPEN_LOOP_SELECT_IN,
   // Motor sensing and sequencing
   input  wire logic [7:0]  SPEED_CMD_IN,
   input  wire logic [15:0] SPEED_IN,
   input  wire logic [15:0] PHASE_U_CURRENT_IN,
   input  wire logic [11:0] BEMF_SAMPLE_IN,
   input  wire logic        BEMF_ZERO_CROSS_IN,
   input  wire logic [2:0]  COMMUTATION_STATE_IN,
   input  wire logic        CLOSED_LOOP_IN,
   input  wire logic [15:0] OPEN_LOOP_RATE_IN,
   input  wire logic [15:0] HANDOFF_THRESHOLD_IN,
   input  wire logic        SUPPLY_AT_24V_IN,
   input  wire logic        LOCK_CURRENT_TRIP_IN,
   input  wire logic        START_IN,
   // Status and drive
   output logic      [5:0]  FAULT_STATUS_OUT,
   output logic             LOCKED_OUT,
   output logic             RESTART_OUT,
   output logic      [7:0]  SPEED_CMD_BUFFER_OUT,
   output logic      [15:0] MEASURED_VELCONST_OUT,
   output logic             HIGH_SIDE_ON_OUT,
   output logic             LOW_SIDE_ON_OUT,
   output logic             TACH_PULSE_OUT
);

   // ***********************************
   // State
   // ***********************************
   typedef struct packed {
      drive_state_t st;
      logic [5:0]   flags;
      logic         locked;
      logic         restart;
      logic         tach;
      logic         hi;
      logic         lo;
      logic [7:0]   cmd_buf;
      logic [31:0]  acc;
      logic [7:0]   integ_cnt;
      logic [15:0]  ktc;
      logic         ktc_valid;
      logic [31:0]  q1;
      logic [31:0]  q2;
      logic [31:0]  timer;
      logic [12:0]  pwm_cnt;
      logic [7:0]   dt_cnt;
      logic         pwm_prev;
      logic [2:0]   sector_prev;
      logic [23:0]  per_cnt;
      logic [23:0]  per_prev;
      logic         ol_armed;
      logic [2:0]   ol_steps;
      logic         cl_prev;
      logic [4:0]   half_cnt;
      logic         first_start;
   } state_t;

   state_t s;
   state_t next_s;
   // Setting is value << shift; result scaled down and saturated
   function automatic logic [15:0] scale_setting(input logic [6:0] set, input logic [15:0] x);
      logic [26:0] p;
      logic [26:0] q;
      p = ({11'h0, x} * {23'h0, set[3:0]}) << set[6:4];
      q = p >> SCALE_SHIFT;
      return (|q[26:16]) ? 16'hffff : q[15:0];
   endfunction
   function automatic logic [15:0] setting_value(input logic [6:0] set);
      return 16'({12'h0, set[3:0]} << set[6:4]);
   endfunction

   // ***********************************
   // Combinational estimates
   // ***********************************
   logic [15:0] bemf_speed;
   logic [15:0] bemf_drop;
   logic [15:0] bemf_current;
   logic [16:0] amp_margin;
   logic [15:0] kt_nom;
   logic [16:0] kt_low;
   logic [16:0] kt_high;
   logic [7:0]  bemf_clamp;
   logic [5:0]  set_vec;
   logic        restart_ev;
   logic        sector_chg;
   logic [12:0] pwm_period;
   logic [20:0] pwm_thr;
   logic        pwm_raw;
   logic [31:0] brake_cycles;
   logic [4:0]  tach_period;
   logic        tach_drive;

   always_comb begin
      bemf_speed   = scale_setting(VELCONST_SETTING_IN, SPEED_IN);                    // [RL2]
      bemf_drop    = scale_setting(RESISTANCE_SETTING_IN, PHASE_U_CURRENT_IN);        // [RL2]
      bemf_current = ({8'h0, s.cmd_buf} > bemf_drop) ? ({8'h0, s.cmd_buf} - bemf_drop) : 16'h0;
      amp_margin   = {9'h0, s.cmd_buf} + {11'h0, s.cmd_buf[7:2]};
      kt_nom       = setting_value(VELCONST_SETTING_IN);
      kt_low       = {1'b0, kt_nom} - {2'b0, kt_nom[15:1]};                             // [RL4]
      kt_high      = {1'b0, kt_nom} + {2'b0, kt_nom[15:1]};                             // [RL4]
      bemf_clamp   = (|bemf_speed[15:8]) ? 8'hff : bemf_speed[7:0];
      restart_ev   = START_IN || (s.st == ST_HIZ && s.timer >= 32'(LOCK_OFF_CYCLES - 1));
      sector_chg   = COMMUTATION_STATE_IN != s.sector_prev;
      pwm_period   = PWM_RATE_SELECT_IN ? 13'(PWM_FAST_CYCLES) : 13'(PWM_SLOW_CYCLES); // [RL15]
      pwm_thr      = 21'({8'h0, pwm_period} * {13'h0, s.cmd_buf}) >> 8;
      pwm_raw      = {8'h0, s.pwm_cnt} < pwm_thr;
      brake_cycles = 32'(BRAKE_DELAY_FIELD_IN) * 32'(BRAKE_STEP_CYCLES);
      tach_period  = {1'b0, TACH_DIVIDER_FIELD_IN} + 5'h1;
      // Fault detection; flags set whatever the enables say
      set_vec                = 6'h0;
      set_vec[FLAG_CURRENT]  = LOCK_CURRENT_TRIP_IN;
      set_vec[FLAG_SPEED]    = CLOSED_LOOP_IN && s.q1 >= 32'(QUALIFY_CYCLES - 1);   // [RL1]
      set_vec[FLAG_VELCONST] = CLOSED_LOOP_IN && s.q2 >= 32'(QUALIFY_CYCLES - 1);   // [RL4]
      set_vec[FLAG_NO_MOTOR] = CLOSED_LOOP_IN && !s.cl_prev
                               && PHASE_U_CURRENT_IN <= NO_MOTOR_MA;                  // [RL5]
      set_vec[FLAG_OL_STUCK] = s.ol_armed && sector_chg && !BEMF_ZERO_CROSS_IN
                               && s.ol_steps == OL_STEPS - 3'h1;                     // [RL6]
      set_vec[FLAG_CL_STUCK] = CLOSED_LOOP_IN && s.per_prev != 24'h0
                               && {1'b0, s.per_cnt} > {s.per_prev, 1'b0};            // [RL7]
      // Tach source: drive state in closed loop, selectable in open loop
      if (CLOSED_LOOP_IN) begin
         tach_drive = 1'b1;                                                           // [RL19]
      end else if (TACH_OPEN_LOOP_SELECT_IN == TACH_OL_HIGH) begin
         tach_drive = 1'b0;                                                           // [RL20]
      end else if (TACH_OPEN_LOOP_SELECT_IN == TACH_OL_FIRST) begin
         tach_drive = s.first_start;                                                  // [RL20]
      end else begin
         tach_drive = 1'b1;
      end
   end

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      next_s         = s;
      next_s.restart = restart_ev;
      next_s.cl_prev = CLOSED_LOOP_IN;
      // Set beats the restart clear so a same-cycle event survives
      next_s.flags = (restart_ev ? FLAGS_RESET : s.flags) | set_vec;                  // [RL21]
      // Speed command buffer with mechanical clamp
      next_s.cmd_buf = SPEED_CMD_IN;
      if (MECH_SURGE_ENABLE_IN && (!MECH_SURGE_MODE_IN || SUPPLY_AT_24V_IN)) begin      // [RL8] [RL10]
         if (bemf_clamp > SPEED_CMD_IN) begin
            next_s.cmd_buf = bemf_clamp;                                              // [RL9]
         end
      end
      // Abnormal speed qualification
      if (CLOSED_LOOP_IN && {1'b0, bemf_speed} > amp_margin && bemf_speed > bemf_current) begin
         next_s.q1 = (s.q1 == 32'hffffffff) ? s.q1 : s.q1 + 32'h1;                    // [RL1]
      end else begin
         next_s.q1 = 32'h0;
      end
      // BEMF integral per half cycle, sampled on a slow tick
      next_s.integ_cnt = (s.integ_cnt >= 8'(INTEG_DIV_CYCLES - 1)) ? 8'h0 : s.integ_cnt + 8'h1;
      if (BEMF_ZERO_CROSS_IN) begin
         next_s.ktc       = 16'(s.acc >> KTC_SHIFT);                                  // [RL3]
         next_s.ktc_valid = 1'b1;
         next_s.acc       = 32'h0;
      end else if (s.integ_cnt == 8'h0) begin
         next_s.acc = s.acc + {20'h0, BEMF_SAMPLE_IN};                                // [RL3]
      end
      if (CLOSED_LOOP_IN && s.ktc_valid
          && ({1'b0, s.ktc} < kt_low || {1'b0, s.ktc} > kt_high)) begin
         next_s.q2 = (s.q2 == 32'hffffffff) ? s.q2 : s.q2 + 32'h1;                    // [RL4]
      end else begin
         next_s.q2 = 32'h0;
      end
      // Commutation period tracking
      next_s.sector_prev = COMMUTATION_STATE_IN;
      if (sector_chg) begin
         next_s.per_prev = s.per_cnt;                                                 // [RL7]
         next_s.per_cnt  = 24'h0;
      end else if (s.per_cnt != 24'hffffff) begin
         next_s.per_cnt = s.per_cnt + 24'h1;
      end
      // Open-loop watch: one electrical cycle of sectors without BEMF
      if (CLOSED_LOOP_IN || BEMF_ZERO_CROSS_IN || restart_ev) begin
         next_s.ol_armed = 1'b0;
         next_s.ol_steps = 3'h0;
      end else if (!s.ol_armed && OPEN_LOOP_RATE_IN > HANDOFF_THRESHOLD_IN) begin
         next_s.ol_armed = 1'b1;                                                      // [RL6]
         next_s.ol_steps = 3'h0;
      end else if (s.ol_armed && sector_chg) begin
         next_s.ol_steps = (s.ol_steps == OL_STEPS - 3'h1) ? 3'h0 : s.ol_steps + 3'h1;
         next_s.ol_armed = s.ol_steps != OL_STEPS - 3'h1;
      end
      // Fault sequencing
      next_s.timer = s.timer + 32'h1;
      case (s.st)
         ST_DRIVE: begin
            next_s.timer = 32'h0;
            if (|(set_vec & LOCK_SCHEME_ENABLES_IN)) begin                            // [RL23]
               next_s.locked = 1'b1;                                                  // [RL22]
               if (INDUCTIVE_SURGE_ENABLE_IN && BRAKE_DELAY_FIELD_IN != 3'h0) begin   // [RL8] [RL12]
                  next_s.st = ST_BRAKE;
               end else begin
                  next_s.st = ST_HIZ;
               end
            end
         end
         ST_BRAKE: begin
            if (s.timer >= brake_cycles - 32'h1) begin
               next_s.st    = ST_HIZ;                                                 // [RL11]
               next_s.timer = 32'h0;
            end
         end
         ST_HIZ: begin
            if (restart_ev) begin
               next_s.st     = ST_DRIVE;                                              // [RL22]
               next_s.locked = 1'b0;
            end
         end
         default: begin
            next_s.st = ST_HIZ;
         end
      endcase
      if (restart_ev && s.restart == 1'b0 && s.st != ST_DRIVE) begin
         next_s.first_start = 1'b0;
      end else if (START_IN && s.st == ST_DRIVE && s.per_prev != 24'h0) begin
         next_s.first_start = 1'b0;
      end
      // PWM carrier and complementary switches with dead time
      next_s.pwm_cnt  = (s.pwm_cnt >= pwm_period - 13'h1) ? 13'h0 : s.pwm_cnt + 13'h1;  // [RL15]
      next_s.pwm_prev = pwm_raw;
      if (pwm_raw != s.pwm_prev) begin
         next_s.dt_cnt = 8'({3'h0, DEAD_TIME_FIELD_IN} + 8'h1) * 8'(DEAD_STEP_CYCLES);  // [RL13]
      end else if (s.dt_cnt != 8'h0) begin
         next_s.dt_cnt = s.dt_cnt - 8'h1;
      end
      if (next_s.st == ST_BRAKE) begin
         next_s.hi = 1'b0;                                                            // [RL11]
         next_s.lo = 1'b1;
      end else if (next_s.st == ST_HIZ) begin
         next_s.hi = 1'b0;
         next_s.lo = 1'b0;
      end else if (next_s.dt_cnt != 8'h0) begin
         next_s.hi = 1'b0;                                                            // [RL13]
         next_s.lo = 1'b0;
      end else begin
         next_s.hi = pwm_raw;
         next_s.lo = !pwm_raw;
      end
      // Tach divider on half electrical cycles; code 0 toggles per cycle
      if (restart_ev) begin
         next_s.half_cnt = 5'h0;                                                      // [RL24]
      end else if (sector_chg && (COMMUTATION_STATE_IN == 3'h0 || COMMUTATION_STATE_IN == SECTOR_HALF)) begin
         next_s.half_cnt = (s.half_cnt >= tach_period - 5'h1) ? 5'h0 : s.half_cnt + 5'h1;  // [RL16] [RL24]
      end
      if (next_s.locked) begin
         next_s.tach = 1'b1;                                                          // [RL19]
      end else if (!tach_drive) begin
         next_s.tach = 1'b1;                                                          // [RL20]
      end else if (TACH_DIVIDER_FIELD_IN == 4'h0) begin
         if (sector_chg && COMMUTATION_STATE_IN == 3'h0 && s.sector_prev == SECTOR_LAST) begin
            next_s.tach = !s.tach;                                                    // [RL16]
         end
      end else begin
         // Odd periods leave the duty uneven; rising edges stay evenly spaced
         next_s.tach = {s.half_cnt, 1'b0} < {1'b0, tach_period};                      // [RL17] [RL18]
      end
   end
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         s             <= '0;
         s.st          <= ST_DRIVE;
         s.flags       <= FLAGS_RESET;
         s.tach        <= 1'b1;
         s.first_start <= 1'b1;
      end else begin
         s <= next_s;
      end
   end
   assign FAULT_STATUS_OUT      = s.flags;
   assign LOCKED_OUT            = s.locked;
   assign RESTART_OUT           = s.restart;
   assign SPEED_CMD_BUFFER_OUT  = s.cmd_buf;
   assign MEASURED_VELCONST_OUT = s.ktc;
   assign HIGH_SIDE_ON_OUT      = s.hi;
   assign LOW_SIDE_ON_OUT       = s.lo;
   assign TACH_PULSE_OUT        = s.tach;

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   lock_to_hiz_a: assert property (                                            // [RL22]
      s.st == ST_DRIVE && |(set_vec & LOCK_SCHEME_ENABLES_IN) |=> s.locked && !s.hi)
      else $error("enabled fault did not stop the bridge");
   flag_when_off_a: assert property (                                          // [RL21]
      LOCK_CURRENT_TRIP_IN |=> s.flags[FLAG_CURRENT])
      else $error("fault flag not set");
   no_motor_a: assert property (                                               // [RL5]
      CLOSED_LOOP_IN && !s.cl_prev && PHASE_U_CURRENT_IN <= NO_MOTOR_MA |=> s.flags[FLAG_NO_MOTOR])
      else $error("no-motor fault missed");
   cl_stuck_a: assert property (                                               // [RL7]
      CLOSED_LOOP_IN && s.per_prev != 24'h0 && {1'b0, s.per_cnt} > {s.per_prev, 1'b0}
      |=> s.flags[FLAG_CL_STUCK])
      else $error("closed-loop stuck missed");
   brake_order_a: assert property (                                            // [RL11]
      s.st == ST_DRIVE ##1 s.st == ST_BRAKE |-> !s.hi && s.lo)
      else $error("brake did not keep low side only");
   no_brake_zero_a: assert property (                                          // [RL12]
      $rose(s.locked) && $past(BRAKE_DELAY_FIELD_IN) == 3'h0 |-> s.st == ST_HIZ)
      else $error("brake applied with zero delay");
   dead_gap_a: assert property (                                               // [RL13]
      s.st == ST_DRIVE && $fell(s.hi) |-> (!s.lo || s.st != ST_DRIVE)[*5])
      else $error("dead time too short");
   tach_locked_a: assert property (                                            // [RL19]
      s.locked |-> s.tach)
      else $error("tach not high while locked");
   mech_clamp_a: assert property (                                             // [RL9]
      MECH_SURGE_ENABLE_IN && !MECH_SURGE_MODE_IN |=> s.cmd_buf >= $past(bemf_clamp))
      else $error("amplitude below speed bemf");
   pwm_rate_a: assert property (                                               // [RL15]
      $past(PWM_RATE_SELECT_IN, 1) && $past(PWM_RATE_SELECT_IN, 2) |-> s.pwm_cnt < 13'(PWM_FAST_CYCLES))
      else $error("pwm period wrong");
endmodule // motor_lock_ctl

/* File: motor_model.sv */
`timescale 1ns/1ns
// ***********************************
// Rotor: six sectors, zero cross each half cycle
// ***********************************
module motor_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] period_in,
   output logic      [2:0]  sector_out,
   output logic             zc_out
);
   logic [15:0] cnt;
   // A zero period is a stuck rotor: no sector change, no crossing
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 16'h0;
         sector_out <= 3'h0;
         zc_out <= 1'b0;
      end else begin
         zc_out <= 1'b0;
         if (period_in != 16'h0 && cnt >= period_in - 16'h1) begin
            cnt <= 16'h0;
            sector_out <= (sector_out == 3'h5) ? 3'h0 : sector_out + 3'h1;
            zc_out <= (sector_out == 3'h5) || (sector_out == 3'h2);
         end else begin
            cnt <= cnt + 16'h1;
         end
      end
   end
endmodule // motor_model

/* File: motor_lock_avs_fg_control_tb.sv */
`timescale 1ns/1ns
module motor_lock_avs_fg_control_tb;
   import motor_lock_pkg::*;
   logic        CLOCK_IN, RST_IN, MECH_SURGE_ENABLE_IN, MECH_SURGE_MODE_IN, INDUCTIVE_SURGE_ENABLE_IN;
   logic        PWM_RATE_SELECT_IN, CLOSED_LOOP_IN, SUPPLY_AT_24V_IN, LOCK_CURRENT_TRIP_IN, START_IN;
   logic        BEMF_ZERO_CROSS_IN, zc, zc_en, LOCKED_OUT, RESTART_OUT, HIGH_SIDE_ON_OUT, LOW_SIDE_ON_OUT;
   logic        TACH_PULSE_OUT;
   logic [6:0]  RESISTANCE_SETTING_IN, VELCONST_SETTING_IN;
   logic [5:0]  LOCK_SCHEME_ENABLES_IN, FAULT_STATUS_OUT;
   logic [4:0]  DEAD_TIME_FIELD_IN;
   logic [3:0]  TACH_DIVIDER_FIELD_IN;
   logic [2:0]  BRAKE_DELAY_FIELD_IN, COMMUTATION_STATE_IN;
   logic [1:0]  TACH_OPEN_LOOP_SELECT_IN;
   logic [7:0]  SPEED_CMD_IN, SPEED_CMD_BUFFER_OUT;
   logic [11:0] BEMF_SAMPLE_IN;
   logic [15:0] SPEED_IN, PHASE_U_CURRENT_IN, OPEN_LOOP_RATE_IN, HANDOFF_THRESHOLD_IN, MEASURED_VELCONST_OUT, period;
   int          failures, cmp_count, edges;
   int          exp_edges [4] = '{6, 12, 8, 6};
   assign BEMF_ZERO_CROSS_IN = zc & zc_en;
   // ***********************************
   // Design and rotor
   // ***********************************
   motor_lock_ctl #(.QUALIFY_CYCLES(20), .LOCK_OFF_CYCLES(50), .BRAKE_STEP_CYCLES(4)) motor_lock_ctl_i (
      .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .RESISTANCE_SETTING_IN(RESISTANCE_SETTING_IN),
      .VELCONST_SETTING_IN(VELCONST_SETTING_IN), .LOCK_SCHEME_ENABLES_IN(LOCK_SCHEME_ENABLES_IN),
      .MECH_SURGE_ENABLE_IN(MECH_SURGE_ENABLE_IN), .MECH_SURGE_MODE_IN(MECH_SURGE_MODE_IN),
      .INDUCTIVE_SURGE_ENABLE_IN(INDUCTIVE_SURGE_ENABLE_IN), .BRAKE_DELAY_FIELD_IN(BRAKE_DELAY_FIELD_IN),
      .DEAD_TIME_FIELD_IN(DEAD_TIME_FIELD_IN), .PWM_RATE_SELECT_IN(PWM_RATE_SELECT_IN),
      .TACH_DIVIDER_FIELD_IN(TACH_DIVIDER_FIELD_IN), .TACH_OPEN_LOOP_SELECT_IN(TACH_OPEN_LOOP_SELECT_IN),
      .SPEED_CMD_IN(SPEED_CMD_IN), .SPEED_IN(SPEED_IN), .PHASE_U_CURRENT_IN(PHASE_U_CURRENT_IN),
      .BEMF_SAMPLE_IN(BEMF_SAMPLE_IN), .BEMF_ZERO_CROSS_IN(BEMF_ZERO_CROSS_IN),
      .COMMUTATION_STATE_IN(COMMUTATION_STATE_IN), .CLOSED_LOOP_IN(CLOSED_LOOP_IN),
      .OPEN_LOOP_RATE_IN(OPEN_LOOP_RATE_IN), .HANDOFF_THRESHOLD_IN(HANDOFF_THRESHOLD_IN),
      .SUPPLY_AT_24V_IN(SUPPLY_AT_24V_IN), .LOCK_CURRENT_TRIP_IN(LOCK_CURRENT_TRIP_IN), .START_IN(START_IN),
      .FAULT_STATUS_OUT(FAULT_STATUS_OUT), .LOCKED_OUT(LOCKED_OUT), .RESTART_OUT(RESTART_OUT),
      .SPEED_CMD_BUFFER_OUT(SPEED_CMD_BUFFER_OUT), .MEASURED_VELCONST_OUT(MEASURED_VELCONST_OUT),
      .HIGH_SIDE_ON_OUT(HIGH_SIDE_ON_OUT), .LOW_SIDE_ON_OUT(LOW_SIDE_ON_OUT), .TACH_PULSE_OUT(TACH_PULSE_OUT));
   motor_model motor_model_i (.clk_in(CLOCK_IN), .rst_in(RST_IN), .period_in(period),
      .sector_out(COMMUTATION_STATE_IN), .zc_out(zc));
   // ***********************************
   // Tasks
   // ***********************************
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge CLOCK_IN);
      #1;
   endtask
   // Code 6 waits for the restart pulse, others for a fault flag
   task automatic wait_for(int code, int limit);
      int n;
      n = 0;
      while (((code == 6) ? RESTART_OUT : FAULT_STATUS_OUT[code]) !== 1'b1) begin
         n++;
         if (n > limit) begin
            check("wait", 16'(code), 16'hffff);
            report_and_stop();
         end
         tick(1);
      end
   endtask
   task automatic pulse_start();
      @(posedge CLOCK_IN);
      START_IN <= 1'b1;
      @(posedge CLOCK_IN);
      START_IN <= 1'b0;
      tick(1);
   endtask
   task automatic trip(logic [2:0] brk);
      @(posedge CLOCK_IN);
      BRAKE_DELAY_FIELD_IN <= brk;
      LOCK_CURRENT_TRIP_IN <= 1'b1;
      @(posedge CLOCK_IN);
      LOCK_CURRENT_TRIP_IN <= 1'b0;
      #1;
      check("flag0", 16'h1, 16'(FAULT_STATUS_OUT[0]));
      check("locked", 16'(LOCK_SCHEME_ENABLES_IN[0]), 16'(LOCKED_OUT));
      if (LOCK_SCHEME_ENABLES_IN[0]) begin
         check("high_side", 16'h0, 16'(HIGH_SIDE_ON_OUT));
         check("low_side", 16'(brk != 3'h0), 16'(LOW_SIDE_ON_OUT));
         check("tach", 16'h1, 16'(TACH_PULSE_OUT));
         if (brk != 3'h0) begin
            tick(4 * brk - 2);
            check("low_side", 16'h1, 16'(LOW_SIDE_ON_OUT));
            tick(3);
            check("low_side", 16'h0, 16'(LOW_SIDE_ON_OUT));
         end
         wait_for(6, 80);
         check("locked", 16'h0, 16'(LOCKED_OUT));
      end else begin
         pulse_start();
      end
      check("flags", 16'h0, 16'(FAULT_STATUS_OUT));
   endtask
   task automatic count_tach(int cycles);
      logic last;
      edges = 0;
      last = TACH_PULSE_OUT;
      repeat (cycles) begin
         tick(1);
         if (!last && TACH_PULSE_OUT === 1'b1) edges++;
         last = TACH_PULSE_OUT;
      end
   endtask
   // ***********************************
   // Clock and sequence
   // ***********************************
   initial begin
      CLOCK_IN = 1'b0;
      forever #4 CLOCK_IN = ~CLOCK_IN;
   end
   initial begin
      {MECH_SURGE_ENABLE_IN, MECH_SURGE_MODE_IN, INDUCTIVE_SURGE_ENABLE_IN, CLOSED_LOOP_IN, SUPPLY_AT_24V_IN} = '0;
      {LOCK_CURRENT_TRIP_IN, START_IN, LOCK_SCHEME_ENABLES_IN, TACH_DIVIDER_FIELD_IN, SPEED_CMD_IN} = '0;
      {BRAKE_DELAY_FIELD_IN, TACH_OPEN_LOOP_SELECT_IN, PHASE_U_CURRENT_IN, failures, cmp_count} = '0;
      {RST_IN, PWM_RATE_SELECT_IN, zc_en} = 3'h7;
      {RESISTANCE_SETTING_IN, VELCONST_SETTING_IN, BEMF_SAMPLE_IN} = {7'h11, 7'h11, 12'h100};
      {SPEED_IN, OPEN_LOOP_RATE_IN, HANDOFF_THRESHOLD_IN, period} = {16'h0100, 16'h0200, 16'h0100, 16'h000a};
      DEAD_TIME_FIELD_IN = 5'h04;
      tick(11);
      check("flags", 16'h0, 16'(FAULT_STATUS_OUT));
      check("tach", 16'h1, 16'(TACH_PULSE_OUT));
      @(posedge CLOCK_IN);
      RST_IN <= 1'b0;
      trip(3'h2);
      LOCK_SCHEME_ENABLES_IN <= 6'h01;
      INDUCTIVE_SURGE_ENABLE_IN <= 1'b1;
      trip(3'h2);
      trip(3'h0);
      LOCK_SCHEME_ENABLES_IN <= 6'h00;
      PHASE_U_CURRENT_IN <= 16'd140;
      @(posedge CLOCK_IN);
      CLOSED_LOOP_IN <= 1'b1;
      wait_for(3, 8);
      CLOSED_LOOP_IN <= 1'b0;
      PHASE_U_CURRENT_IN <= 16'd141;
      pulse_start();
      @(posedge CLOCK_IN);
      CLOSED_LOOP_IN <= 1'b1;
      tick(200);
      check("flag3", 16'h0, 16'(FAULT_STATUS_OUT[3]));
      check("flag5", 16'h0, 16'(FAULT_STATUS_OUT[5]));
      check("flags", 16'h6, 16'(FAULT_STATUS_OUT));
      check("velconst", 16'h0, MEASURED_VELCONST_OUT);
      period <= 16'd40;
      wait_for(5, 400);
      period <= 16'd10;
      for (int i = 0; i < 4; i++) begin
         TACH_DIVIDER_FIELD_IN <= 4'(i);
         pulse_start();
         count_tach(720);
         check("tach_edges", 16'h1, 16'(edges >= exp_edges[i] - 1 && edges <= exp_edges[i] + 1));
      end
      CLOSED_LOOP_IN <= 1'b0;
      TACH_OPEN_LOOP_SELECT_IN <= TACH_OL_HIGH;
      pulse_start();
      count_tach(720);
      check("tach_edges", 16'h0, 16'(edges));
      zc_en <= 1'b0;
      pulse_start();
      wait_for(4, 200);
      {zc_en, CLOSED_LOOP_IN, MECH_SURGE_ENABLE_IN, SPEED_IN, VELCONST_SETTING_IN} <= {3'h7, 16'hffff, 7'h7f};
      tick(4);
      check("clamp", 16'hff, 16'(SPEED_CMD_BUFFER_OUT));
      MECH_SURGE_MODE_IN <= 1'b1;
      tick(4);
      check("buffer", 16'h0, 16'(SPEED_CMD_BUFFER_OUT));
      SUPPLY_AT_24V_IN <= 1'b1;
      tick(4);
      check("clamp", 16'hff, 16'(SPEED_CMD_BUFFER_OUT));
      MECH_SURGE_ENABLE_IN <= 1'b0;
      tick(4);
      check("buffer", 16'h0, 16'(SPEED_CMD_BUFFER_OUT));
      {SPEED_CMD_IN, PWM_RATE_SELECT_IN} <= 9'h100;
      tick(5000);
      edges = 0;
      repeat (5000) begin
         tick(1);
         edges += 65536 * LOW_SIDE_ON_OUT + HIGH_SIDE_ON_OUT;
      end
      check("high_time", 16'd2475, 16'(edges));
      check("low_time", 16'd2475, 16'(edges >> 16));
      report_and_stop();
   end
endmodule // motor_lock_avs_fg_control_tb
